//--- design/led_flash_pkg.sv
// Constants, mode codes, register map and carrier types for the LED flash controller.
// Assumes a 100 MHz core clock and a single AHB-Lite master.
package led_flash_pkg;

    // ==================================================================
    // Clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEOUT_MS = 820;
    localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int DIMMER_PWM_HZ = 122;
    localparam int DIMMER_PERIOD_CYCLES = CLK_HZ / DIMMER_PWM_HZ;
    localparam int DIMMER_DUTY_PERMILLE = 63;
    localparam int DIMMER_ON_CYCLES = DIMMER_PERIOD_CYCLES * DIMMER_DUTY_PERMILLE / 1000;
    localparam int RAMP_STEP_NS = 4000;
    localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_W = 9;

    // ==================================================================
    // Mode select codes {mode_select_high, mode_select_low}
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TORCH = 2'h1;
    localparam logic [1:0] MODE_FLASH = 2'h2;
    localparam logic [1:0] MODE_VOLTAGE = 2'h3;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_TORCH = 5'h02,
        ST_FLASH = 5'h04,
        ST_VOLT = 5'h08,
        ST_HOT = 5'h10
    } state_e;

    // ==================================================================
    // Synchroniser bit positions
    localparam int SYNC_N = 6;
    localparam int SYNC_MODE_LO = 0;
    localparam int SYNC_MODE_HI = 1;
    localparam int SYNC_STROBE = 2;
    localparam int SYNC_MASK = 3;
    localparam int SYNC_UVLO = 4;
    localparam int SYNC_HOT = 5;

    // ==================================================================
    // Register map and bus codes
    localparam int DEC_W = 8;
    localparam logic [DEC_W-1:0] REG_CTRL = 8'h00;
    localparam logic [DEC_W-1:0] REG_STATUS = 8'h04;
    localparam logic [DEC_W-1:0] REG_TIMER = 8'h08;
    localparam int REF_W = 8;
    localparam logic [REF_W-1:0] CTRL_RESET = 8'h01;
    localparam logic [REF_W-1:0] REF_FULL = 8'hFF;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;

    // ==================================================================
    // Power stage controls
    typedef struct packed {
        logic switch_on;
        logic rectifier_on;
        logic led_sink_on;
        logic flash_level;
        logic current_regulation;
        logic voltage_regulation;
    } power_s;

endpackage

//--- design/cycle_counter.sv
// Free-running cycle counter with clear, run and wrap at a fixed limit.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module cycle_counter #(
    parameter int WIDTH = 8,
    parameter int LIMIT = 16
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Control
    input wire logic clear,
    input wire logic run,
    // Status
    output logic [WIDTH-1:0] count_q,
    output logic at_last
);

    // ==================================================================
    // Parameter check
    if (LIMIT < 2 || WIDTH > 31 || LIMIT > (1 << WIDTH))
    begin : g_bad_limit
        $error("cycle_counter limit does not fit its width");
    end

    // ==================================================================
    // Counter
    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
    logic [WIDTH-1:0] count_d;

    assign at_last = (count_q == LAST);
    // Clear beats run so a restart never sees a stale count
    assign count_d = clear ? '0 : (!run ? count_q : (at_last ? '0 : count_q + ONE));

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_q <= '0;
        else if (ce)
            count_q <= count_d;
    end

endmodule
`default_nettype wire

//--- design/led_flash_ctrl.sv
// Mode decode, flash safety timer, masking, low-light dimming, soft-start and
// thermal latch for a white-LED boost driver, with an AHB-Lite register slave.
// Assumes pins and analog comparator flags arrive asynchronously; bus on clk.
//
// Operation
// - Both mode selects low: power stage shut down, LED not driven.
// - Mode 01: LED on at torch current, current regulation.
// - Mode 10: LED on for flash, current regulation.
// - Mode 11: LED off, fixed output voltage regulation.
// - In flash mode, strobe high gives flash level, else torch level.
// - Strobe rising edge starts the fixed 820 ms safety timer.
// - Strobe falling edge or time-out stops the safety timer.
// - Time-out with strobe high ends the flash level current.
// - Mask asserted drops LED current from flash to torch level.
// - Mask is active high; its rise starts the drop to torch.
// - Mask never pauses, restarts or alters the safety timer.
// - Leaving shutdown switches at once and ramps the reference gradually.
// - Shutdown stops switching, both transistors off, LED pin floating.
// - Undervoltage lockout inhibits switch and rectifier turn-on.
// - Over-temperature enters thermal shutdown, boost and LED regulator off.
// - Thermal shutdown stays latched until shutdown mode is selected.
// - Low-light dimming gates torch current with a 122 Hz PWM.
// - Dimming PWM keeps torch on for 6.3 percent of each period.
// - Dimming only in torch mode with strobe high.
`timescale 1ns/1ns
`default_nettype none
module led_flash_ctrl
    import led_flash_pkg::*;
#(
    parameter int TIMEOUT_CYCLES_P = TIMEOUT_CYCLES,
    parameter int DIMMER_PERIOD_P = DIMMER_PERIOD_CYCLES,
    parameter int DIMMER_ON_P = DIMMER_ON_CYCLES,
    parameter int TIMER_W = 27,
    parameter int DIMMER_W = 20
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Control pins
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic flash_strobe,
    input wire logic flash_mask,
    // Analog monitor flags
    input wire logic uvlo_active,
    input wire logic over_temp,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_q,
    output logic hreadyout_q,
    output logic hresp_q,
    // Power stage
    output power_s power_q,
    output logic [REF_W-1:0] ref_level_q
);

    // ==================================================================
    // Parameter checks
    if (TIMER_W > 31 || TIMEOUT_CYCLES_P > (1 << TIMER_W) || TIMEOUT_CYCLES_P < 2)
    begin : g_bad_timer
        $error("safety timer count does not fit TIMER_W");
    end
    if (DIMMER_W > 31 || DIMMER_PERIOD_P > (1 << DIMMER_W) || DIMMER_ON_P < 1
        || DIMMER_ON_P >= DIMMER_PERIOD_P)
    begin : g_bad_dimmer
        $error("dimmer period or on time not servable");
    end

    // ==================================================================
    // Input synchronisers
    logic [SYNC_N-1:0] pins_w;
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;

    assign pins_w[SYNC_MODE_LO] = mode_select_low;
    assign pins_w[SYNC_MODE_HI] = mode_select_high;
    assign pins_w[SYNC_STROBE] = flash_strobe;
    assign pins_w[SYNC_MASK] = flash_mask;
    assign pins_w[SYNC_UVLO] = uvlo_active;
    assign pins_w[SYNC_HOT] = over_temp;

    for (genvar i = 0; i < SYNC_N; i++)
    begin : g_sync
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
            end
            else if (ce)
            begin
                sync1_q[i] <= pins_w[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    logic [1:0] mode_w;
    logic strobe_w;
    logic mask_w;
    logic uvlo_w;
    logic hot_w;

    assign mode_w = {sync2_q[SYNC_MODE_HI], sync2_q[SYNC_MODE_LO]};
    assign strobe_w = sync2_q[SYNC_STROBE];
    assign mask_w = sync2_q[SYNC_MASK];
    assign uvlo_w = sync2_q[SYNC_UVLO];
    assign hot_w = sync2_q[SYNC_HOT];

    // ==================================================================
    // Mode state machine
    state_e state_q;
    state_e state_d;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            // Thermal latch: only a pass through shutdown releases it
            // thermal latch release
            ST_HOT:
                if (mode_w == MODE_OFF)
                    state_d = ST_OFF;
            default:
                if (hot_w && mode_w != MODE_OFF)
                    state_d = ST_HOT;
                else
                begin
                    case (mode_w)
                        MODE_TORCH: state_d = ST_TORCH;
                        MODE_FLASH: state_d = ST_FLASH;
                        MODE_VOLTAGE: state_d = ST_VOLT;
                        default: state_d = ST_OFF;
                    endcase
                end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= ST_OFF;
        else if (ce)
            state_q <= state_d;
    end

    // ==================================================================
    // Flash safety timer
    logic strobe_prev_q;
    logic strobe_rise_w;
    logic expired_q;
    logic expired_d;
    logic timer_run_w;
    logic timer_clear_w;
    logic timer_last_w;
    logic timeout_w;
    logic [TIMER_W-1:0] timer_count;

    assign strobe_rise_w = strobe_w & ~strobe_prev_q;
    // Mask is absent on purpose: it must not touch the timer
    // timer start stop
    assign timer_clear_w = strobe_rise_w | ~strobe_w;
    assign timer_run_w = strobe_w & ~expired_q;
    assign timeout_w = timer_run_w & timer_last_w;
    assign expired_d = timeout_w | (expired_q & ~strobe_rise_w);

    cycle_counter #(
        .WIDTH(TIMER_W),
        .LIMIT(TIMEOUT_CYCLES_P)
    ) u_safety_timer (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .clear(timer_clear_w),
        .run(timer_run_w),
        .count_q(timer_count),
        .at_last(timer_last_w)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strobe_prev_q <= 1'b0;
            expired_q <= 1'b0;
        end
        else if (ce)
        begin
            strobe_prev_q <= strobe_w;
            expired_q <= expired_d;
        end
    end

    // ==================================================================
    // Low-light dimmer
    logic dimmer_on_w;
    logic dimmer_gate_w;
    logic [DIMMER_W-1:0] dimmer_count;

    assign dimmer_on_w = (state_q == ST_TORCH) & strobe_w;
    assign dimmer_gate_w = dimmer_count < DIMMER_W'(DIMMER_ON_P);

    cycle_counter #(
        .WIDTH(DIMMER_W),
        .LIMIT(DIMMER_PERIOD_P)
    ) u_dimmer_pwm (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .clear(~dimmer_on_w),
        .run(dimmer_on_w),
        .count_q(dimmer_count),
        .at_last()
    );

    // ==================================================================
    // Soft-start reference ramp
    logic [REF_W-1:0] ctrl_q;
    logic [REF_W-1:0] ramp_step_w;
    logic active_w;
    logic ramp_tick_w;
    logic ramp_last_w;
    logic [REF_W:0] ref_sum_w;
    logic [REF_W-1:0] ref_level_d;
    logic [RAMP_W-1:0] ramp_count;

    assign active_w = (state_q == ST_TORCH) | (state_q == ST_FLASH) | (state_q == ST_VOLT);
    // Zero step would freeze the ramp, so it counts as the smallest step
    assign ramp_step_w = (ctrl_q == '0) ? REF_W'(1) : ctrl_q;
    assign ramp_tick_w = active_w & ramp_last_w;
    assign ref_sum_w = {1'b0, ref_level_q} + {1'b0, ramp_step_w};
    assign ref_level_d = !active_w ? '0
        : (!ramp_tick_w ? ref_level_q : (ref_sum_w[REF_W] ? REF_FULL : ref_sum_w[REF_W-1:0]));

    cycle_counter #(
        .WIDTH(RAMP_W),
        .LIMIT(RAMP_STEP_CYCLES)
    ) u_ramp_prescale (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .clear(~active_w),
        .run(active_w),
        .count_q(ramp_count),
        .at_last(ramp_last_w)
    );

    // ==================================================================
    // Power stage decode
    power_s power_d;

    // switching gated by mode and lockout
    assign power_d.switch_on = active_w & ~uvlo_w;
    assign power_d.rectifier_on = active_w & ~uvlo_w;
    assign power_d.flash_level = (state_q == ST_FLASH) & strobe_w & ~mask_w
        & ~expired_d;
    assign power_d.led_sink_on = (state_q == ST_FLASH)
        | ((state_q == ST_TORCH) & (~dimmer_on_w | dimmer_gate_w));
    assign power_d.current_regulation = (state_q == ST_TORCH) | (state_q == ST_FLASH);
    assign power_d.voltage_regulation = (state_q == ST_VOLT);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_q <= '0;
            ref_level_q <= '0;
        end
        else if (ce)
        begin
            power_q <= power_d;
            ref_level_q <= ref_level_d;
        end
    end

    // ==================================================================
    // AHB-Lite register slave
    logic accept_w;
    logic wr_pend_q;
    logic [DEC_W-1:0] wr_addr_q;
    logic wr_ctrl_w;
    logic [REF_W-1:0] ctrl_now_w;
    logic [31:0] status_w;
    logic [31:0] read_w;

    assign accept_w = hsel & hready & htrans[1];
    assign wr_ctrl_w = wr_pend_q & (wr_addr_q == REG_CTRL);
    // Forwarding keeps a read right after a write coherent
    assign ctrl_now_w = wr_ctrl_w ? hwdata[REF_W-1:0] : ctrl_q;
    assign status_w = {16'h0000, ref_level_q, uvlo_w, dimmer_on_w, expired_q, state_q};
    assign read_w = (haddr[DEC_W-1:0] == REG_CTRL) ? 32'(ctrl_now_w)
        : (haddr[DEC_W-1:0] == REG_STATUS) ? status_w
        : (haddr[DEC_W-1:0] == REG_TIMER) ? 32'(timer_count)
        : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            ctrl_q <= CTRL_RESET;
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= HRESP_OKAY;
        end
        else if (ce)
        begin
            wr_pend_q <= accept_w & hwrite;
            wr_addr_q <= haddr[DEC_W-1:0];
            if (wr_ctrl_w)
                ctrl_q <= hwdata[REF_W-1:0];
            if (accept_w && !hwrite)
                hrdata_q <= read_w;
            hreadyout_q <= 1'b1;
            hresp_q <= HRESP_OKAY;
        end
    end

    // ==================================================================
    // Checks
    chk_off_quiet: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q == ST_OFF |=> !power_q.led_sink_on && !power_q.current_regulation)
        else $error("shutdown still drives the LED");

    chk_off_stage: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q == ST_OFF |=> !power_q.switch_on && !power_q.rectifier_on)
        else $error("shutdown still switching");

    chk_torch_mode: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q != ST_HOT && !hot_w && mode_w == MODE_TORCH
        ##1 ce && !strobe_w |=> power_q.led_sink_on && power_q.current_regulation)
        else $error("torch mode did not light the LED");

    chk_flash_mode: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q != ST_HOT && !hot_w && mode_w == MODE_FLASH
        |=> state_q == ST_FLASH ##0 ce [*1] ##1 power_q.led_sink_on)
        else $error("flash mode did not enable the LED");

    chk_volt_mode: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q == ST_VOLT |=> power_q.voltage_regulation && !power_q.led_sink_on)
        else $error("voltage mode left the LED on");

    chk_flash_level: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q == ST_FLASH && strobe_w && !mask_w && !expired_q && !timeout_w
        |=> power_q.flash_level)
        else $error("strobe high gave no flash level");

    chk_timer_start: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && strobe_rise_w |=> timer_count == '0 && !expired_q)
        else $error("strobe rise did not restart the timer");

    chk_timer_stop: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && !strobe_w |=> timer_count == '0)
        else $error("timer kept counting with strobe low");

    chk_timeout_cut: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && timer_run_w && timer_count == TIMER_W'(TIMEOUT_CYCLES_P - 1)
        |=> expired_q && !power_q.flash_level)
        else $error("flash outlived the safety time-out");

    chk_mask_torch: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && mask_w |=> !power_q.flash_level)
        else $error("mask did not drop to torch level");

    chk_mask_timer: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && timer_run_w && !timer_last_w && !strobe_rise_w
        |=> timer_count == $past(timer_count) + TIMER_W'(1))
        else $error("safety timer disturbed while running");

    chk_uvlo_gate: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && uvlo_w |=> !power_q.switch_on && !power_q.rectifier_on)
        else $error("switching during undervoltage lockout");

    chk_hot_off: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q == ST_HOT |=> !power_q.switch_on && !power_q.led_sink_on)
        else $error("thermal shutdown left the stage on");

    chk_hot_latch: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && state_q == ST_HOT && mode_w != MODE_OFF |=> state_q == ST_HOT)
        else $error("thermal latch released without shutdown");

    chk_dimmer_duty: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && dimmer_on_w && dimmer_count >= DIMMER_W'(DIMMER_ON_P) && state_d == ST_TORCH
        |=> !power_q.led_sink_on)
        else $error("dimmer on beyond its duty");

endmodule
`default_nettype wire

//--- verification/host_pins.sv
// Host GPIO and camera strobe model that drives the control pins.
// Assumes the bench sets the wanted levels just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module host_pins (
    // Clock
    input wire logic clk,
    // Wanted levels
    input wire logic [1:0] want_mode,
    input wire logic want_strobe,
    input wire logic want_mask,
    // Pins
    output logic mode_select_high,
    output logic mode_select_low,
    output logic flash_strobe,
    output logic flash_mask
);
    // ==================================================================
    // Pin drivers
    // Wanted levels registered on each rising edge
    always @(posedge clk)
    begin
        {mode_select_high, mode_select_low} <= want_mode;
        flash_strobe <= want_strobe;
        flash_mask <= want_mask;
    end
endmodule
`default_nettype wire

//--- verification/tb_led_flash_mode_control.sv
// Self-checking bench for the LED flash controller.
// Assumes the host pin model and zero-wait AHB-Lite slave behaviour.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb_led_flash_mode_control
    import led_flash_pkg::*;
;
    // ==================================================================
    // Signals
    localparam int TO_P = 50;
    localparam int DIM_P = 64;
    localparam int DIM_ON = 4;
    localparam int RUN_NS = 200_000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] want_mode = MODE_OFF;
    logic want_strobe = 1'b0;
    logic want_mask = 1'b0;
    logic uvlo_active = 1'b0;
    logic over_temp = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    power_s power_q;
    logic [REF_W-1:0] ref_level_q;
    logic mode_select_low, mode_select_high, flash_strobe, flash_mask;
    logic [31:0] rd;
    int err_count = 0;
    int cmp_count = 0;
    wire logic [3:0] led4 = {power_q.led_sink_on, power_q.flash_level,
        power_q.current_regulation, power_q.voltage_regulation};

    always #5 clk = ~clk;

    host_pins pins (.clk(clk), .want_mode(want_mode), .want_strobe(want_strobe),
        .want_mask(want_mask), .mode_select_high(mode_select_high),
        .mode_select_low(mode_select_low), .flash_strobe(flash_strobe),
        .flash_mask(flash_mask));

    led_flash_ctrl #(.TIMEOUT_CYCLES_P(TO_P), .DIMMER_PERIOD_P(DIM_P), .DIMMER_ON_P(DIM_ON)) dut (
        .clk(clk), .rst_b(rst_b), .ce(ce), .mode_select_low(mode_select_low),
        .mode_select_high(mode_select_high), .flash_strobe(flash_strobe),
        .flash_mask(flash_mask), .uvlo_active(uvlo_active), .over_temp(over_temp),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout_q), .hrdata_q(hrdata_q),
        .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .power_q(power_q),
        .ref_level_q(ref_level_q));

    // ==================================================================
    // Shared tasks
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Pins pass the model and a two-flop sync, so allow several cycles
    task automatic go(input logic [1:0] m, input logic s, input logic k, input int n);
        @(posedge clk);
        want_mode <= m;
        want_strobe <= s;
        want_mask <= k;
        settle(n);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= 32'(a);
        hwrite <= w;
        do @(posedge clk); while (hreadyout_q !== 1'b1);
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        do @(posedge clk); while (hreadyout_q !== 1'b1);
        rd = hrdata_q;
        hsel <= 1'b0;
        `CHK(hresp_q, HRESP_OKAY)
    endtask

    // ==================================================================
    // Scenarios
    task automatic t_regs();
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b1, REG_CTRL, 32'h5);
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK(rd, 32'h5)
        bus(1'b1, REG_STATUS, 32'hFF);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h01)
        bus(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h0)
        $display("test regs done");
    endtask

    task automatic t_modes();
        go(MODE_OFF, 1'b0, 1'b0, 8);
        `CHK(power_q, '0)
        `CHK(ref_level_q, 8'h00)
        go(MODE_TORCH, 1'b0, 1'b0, 8);
        `CHK(led4, 4'hA)
        `CHK(power_q.switch_on, 1'b1)
        `CHK(ref_level_q !== REF_FULL, 1'b1)
        // One ramp step of 400 cycles with the step of 5 written above
        settle(400);
        `CHK(ref_level_q, 8'h05)
        go(MODE_FLASH, 1'b0, 1'b0, 8);
        `CHK(led4, 4'hA)
        go(MODE_VOLTAGE, 1'b0, 1'b0, 8);
        `CHK(led4, 4'h1)
        go(MODE_OFF, 1'b0, 1'b0, 8);
        `CHK(power_q, '0)
        $display("test modes done");
    endtask

    task automatic t_flash();
        logic [31:0] t0;
        go(MODE_FLASH, 1'b0, 1'b0, 8);
        go(MODE_FLASH, 1'b1, 1'b0, 8);
        `CHK(led4, 4'hE)
        go(MODE_FLASH, 1'b1, 1'b1, 8);
        `CHK(led4, 4'hA)
        go(MODE_FLASH, 1'b1, 1'b0, 8);
        `CHK(led4, 4'hE)
        // A restarted timer would still hold flash level here
        settle(34);
        `CHK(led4, 4'hA)
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[5:0], 6'h24)
        bus(1'b0, REG_TIMER, 32'h0);
        t0 = rd;
        bus(1'b0, REG_TIMER, 32'h0);
        `CHK(rd, t0)
        go(MODE_FLASH, 1'b0, 1'b0, 8);
        bus(1'b0, REG_TIMER, 32'h0);
        `CHK(rd, 32'h0)
        go(MODE_FLASH, 1'b1, 1'b0, 8);
        `CHK(led4, 4'hE)
        go(MODE_FLASH, 1'b0, 1'b0, 8);
        `CHK(led4, 4'hA)
        $display("test flash done");
    endtask

    task automatic t_dim();
        int on_cnt;
        for (int b = 0; b < 2; b++)
        begin
            go(MODE_TORCH, 1'b1, 1'b0, 20);
            on_cnt = 0;
            repeat (4 * DIM_P)
            begin
                @(negedge clk);
                on_cnt += int'(power_q.led_sink_on === 1'b1);
            end
            `CHK(on_cnt, 4 * DIM_ON)
            go(MODE_OFF, 1'b1, 1'b0, 8);
            `CHK(power_q.led_sink_on, 1'b0)
        end
        $display("test dimming done");
    endtask

    task automatic t_fault();
        go(MODE_TORCH, 1'b0, 1'b0, 8);
        @(posedge clk);
        over_temp <= 1'b1;
        settle(8);
        `CHK(power_q, '0)
        @(posedge clk);
        over_temp <= 1'b0;
        settle(8);
        `CHK(power_q, '0)
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h10)
        go(MODE_OFF, 1'b0, 1'b0, 8);
        go(MODE_TORCH, 1'b0, 1'b0, 8);
        `CHK(led4, 4'hA)
        @(posedge clk);
        uvlo_active <= 1'b1;
        settle(8);
        `CHK({power_q.switch_on, power_q.rectifier_on, power_q.led_sink_on}, 3'h1)
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[7], 1'b1)
        @(posedge clk);
        uvlo_active <= 1'b0;
        settle(8);
        `CHK(power_q.switch_on, 1'b1)
        // Enable low freezes every flop, so torch must persist
        @(posedge clk);
        ce <= 1'b0;
        go(MODE_OFF, 1'b0, 1'b0, 8);
        `CHK(led4, 4'hA)
        @(posedge clk);
        ce <= 1'b1;
        settle(8);
        `CHK(power_q, '0)
        $display("test faults done");
    endtask

    // ==================================================================
    // Run control
    task automatic conclude();
        $display("compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        settle(2);
        t_regs();
        t_modes();
        t_flash();
        t_dim();
        t_fault();
        conclude();
    end

    // Whole run is about 1250 cycles; the limit of 20000 cycles leaves wide margin
    initial
    begin
        #RUN_NS;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
